// ---- cic_pkg.sv ----
package cic_pkg;

    // ----------------------------------------------------------------
    // timing and layout constants
    // ----------------------------------------------------------------
    localparam int unsigned     UNDEF_CYCLES    = 4;
    localparam logic [2:0]      UNDEF_LAST      = 3'h3;
    localparam logic [31:0]     PC_STORE_OFFSET = 32'h0000_0008;
    localparam logic [31:0]     UNDEF_VECTOR    = 32'h0000_0004;
    localparam logic [3:0]      PREFETCH_DEPTH  = 4'hC;
    localparam logic [3:0]      PROGRAM_COUNTER_REG = 4'hF;
    localparam logic [1:0]      PENALTY_NONE    = 2'h0;
    localparam logic [1:0]      PENALTY_NORMAL  = 2'h1;
    localparam logic [1:0]      PENALTY_LATE    = 2'h2;
    // barrier encoding: software interrupt with this immediate (arbitrary)
    localparam logic [23:0]     BARRIER_IMM     = 24'hF0_0000;
    localparam logic [3:0]      COND_NEVER      = 4'hF;
    localparam logic [2:0]      CLASS_MEDIA     = 3'h3;
    localparam logic [3:0]      CLASS_SWI       = 4'hF;
    localparam logic [3:0]      CLASS_CP_REG    = 4'hE;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CIC_RUN   = 2'b00,
        CIC_STALL = 2'b01,
        CIC_TRAP  = 2'b10
    } cic_state_e;

    // instruction offered by the fetch side
    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [31:0] pc;
    } cic_dec_s;

    // requests toward memory
    typedef struct packed {
        logic [31:0] addr;
        logic        addr_ask;
        logic        read_ask_data;
        logic        read_ask_instr_core;
        logic        read_ask_instr_prefetch;
        logic        privileged;
        logic        narrow_addr_mode_flag;
    } cic_mreq_s;

    // responses from memory
    typedef struct packed {
        logic        addr_reply;
        logic        read_reply;
        logic        data_side_used_up;
        logic        instr_side_used_up;
    } cic_mrsp_s;

endpackage : cic_pkg

// ---- cic_core_ctl.sv ----
`timescale 1ns/1ps

module cic_core_ctl (
    // clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_rst_n,
    // decode stage
    input  wire cic_pkg::cic_dec_s  i_dec,
    output logic                    o_dec_ready,
    // register file values for execute
    input  wire logic [31:0]        i_base_val,
    input  wire logic [1:0]         i_ea_lo,
    input  wire logic               i_st_beat,
    input  wire logic [3:0]         i_st_reg,
    input  wire logic [31:0]        i_st_val,
    input  wire logic               i_data_abort,
    // memory interface
    input  wire cic_pkg::cic_mreq_s i_req,
    input  wire cic_pkg::cic_mrsp_s i_rsp,
    input  wire logic               i_confirm,
    output cic_pkg::cic_mreq_s      o_req,
    output cic_pkg::cic_mrsp_s      o_rsp,
    // prefetch occupancy
    input  wire logic               i_pf_push,
    input  wire logic               i_pf_pop,
    output logic                    o_pf_ready,
    output logic                    o_pf_flush,
    // execute side results
    output logic                    o_interlock,
    output logic                    o_undef_take,
    output logic [31:0]             o_undef_vector,
    output logic [31:0]             o_store_data,
    output logic                    o_store_valid,
    output logic                    o_base_restore,
    output logic [3:0]              o_base_reg,
    output logic [31:0]             o_base_val,
    output logic                    o_no_defined_result
);

    // ----------------------------------------------------------------
    // reset synchroniser
    // ----------------------------------------------------------------
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ----------------------------------------------------------------
    // decode classification
    // ----------------------------------------------------------------
    logic [31:0] ins;
    logic [3:0]  f_rn;
    logic [3:0]  f_rm;
    logic [3:0]  f_rs;
    logic [3:0]  f_rd;
    logic        is_xfer;
    logic        is_load;
    logic        is_store;
    logic        is_regshift;
    logic        is_undef;
    logic        is_barrier;
    logic        is_cp_move;
    logic        bad_encoding;

    assign ins         = i_dec.instr;
    assign f_rn        = ins[19:16];
    assign f_rm        = ins[3:0];
    assign f_rs        = ins[11:8];
    assign f_rd        = ins[15:12];
    assign is_xfer     = (ins[27:26] == 2'b01) && !is_undef;
    assign is_load     = is_xfer && ins[20];
    assign is_store    = is_xfer && !ins[20];
    assign is_regshift = (ins[27:25] == 3'b000) && ins[4] && !ins[7];
    assign is_cp_move  = (ins[27:24] == cic_pkg::CLASS_CP_REG) && ins[4] && !ins[20];
    // unallocated space never aliases onto a load or store
    assign is_undef    = (ins[31:28] == cic_pkg::COND_NEVER)
                       || ((ins[27:25] == cic_pkg::CLASS_MEDIA) && ins[4]);
    assign is_barrier  = (ins[27:24] == cic_pkg::CLASS_SWI)
                       && (ins[23:0] == cic_pkg::BARRIER_IMM);
    // encodings whose result is left undefined are flagged, not trapped
    assign bad_encoding = (is_regshift && ((f_rn == cic_pkg::PROGRAM_COUNTER_REG)
                            || (f_rm == cic_pkg::PROGRAM_COUNTER_REG)))
                        || (is_cp_move && (f_rd == cic_pkg::PROGRAM_COUNTER_REG))
                        || (is_load && (!ins[24] || ins[21]) && (f_rd == f_rn));

    // ----------------------------------------------------------------
    // load-use hazard against the two older instructions
    // ----------------------------------------------------------------
    logic        ex_load;
    logic        ex_late;
    logic [3:0]  ex_rd;
    logic        mem_load;
    logic        mem_late;
    logic [3:0]  mem_rd;
    logic [31:0] ex_pc;
    logic        ex_xfer_pc;
    logic [1:0]  penalty;

    // address operands are needed early, store data only late
    function automatic logic reads_early(input logic [31:0] w, input logic [3:0] r);
        reads_early = (w[19:16] == r) || (w[3:0] == r)
                    || ((w[27:25] == 3'b000) && w[4] && (w[11:8] == r));
    endfunction : reads_early

    always_comb begin
        penalty = cic_pkg::PENALTY_NONE;
        if (i_dec.valid && !is_undef) begin
            if (mem_load && mem_late && reads_early(ins, mem_rd))
                penalty = cic_pkg::PENALTY_NORMAL;
            if (ex_load && reads_early(ins, ex_rd))
                penalty = ex_late ? cic_pkg::PENALTY_LATE
                                  : cic_pkg::PENALTY_NORMAL;
            else if (ex_load && is_store && (f_rd == ex_rd) && ex_late)
                penalty = cic_pkg::PENALTY_NORMAL;
        end
    end

    // ----------------------------------------------------------------
    // pipeline control state machine
    // ----------------------------------------------------------------
    cic_pkg::cic_state_e state;
    cic_pkg::cic_state_e next_state;
    logic [2:0]  cnt;
    logic        advance;

    // confirm stretches the cycle: decode is not taken until it drops
    assign advance     = (state == cic_pkg::CIC_RUN) && i_dec.valid && !i_confirm
                       && (penalty == cic_pkg::PENALTY_NONE);
    assign o_dec_ready = advance;

    always_comb begin
        next_state = state;
        unique case (state)
            cic_pkg::CIC_RUN: begin
                if (i_dec.valid && !i_confirm && is_undef)
                    next_state = cic_pkg::CIC_TRAP;
                else if (i_dec.valid && !i_confirm && penalty != cic_pkg::PENALTY_NONE)
                    next_state = cic_pkg::CIC_STALL;
            end
            cic_pkg::CIC_STALL: begin
                if (cnt == 3'h0)
                    next_state = cic_pkg::CIC_RUN;
            end
            cic_pkg::CIC_TRAP: begin
                if (cnt == cic_pkg::UNDEF_LAST)
                    next_state = cic_pkg::CIC_RUN;
            end
            default: next_state = cic_pkg::CIC_RUN;
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= cic_pkg::CIC_RUN;
            cnt   <= 3'h0;
        end else begin
            state <= next_state;
            if (state == cic_pkg::CIC_RUN)
                cnt <= (is_undef ? 3'h0 : {1'b0, penalty} - 3'h1);
            else if (state == cic_pkg::CIC_TRAP)
                cnt <= cnt + 3'h1;
            else
                cnt <= cnt - 3'h1;
        end
    end

    // execute repeats while held; flag seen by the coprocessor
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n)
            o_interlock <= 1'b0;
        else
            o_interlock <= (next_state == cic_pkg::CIC_STALL);
    end

    // trap entry after its fixed cost
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_undef_take   <= 1'b0;
            o_undef_vector <= 32'h0000_0000;
        end else begin
            o_undef_take   <= (state == cic_pkg::CIC_TRAP)
                            && (cnt == cic_pkg::UNDEF_LAST);
            o_undef_vector <= cic_pkg::UNDEF_VECTOR;
        end
    end

    // ----------------------------------------------------------------
    // execute and memory stage tracking
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ex_load    <= 1'b0;
            ex_late    <= 1'b0;
            ex_rd      <= 4'h0;
            ex_pc      <= 32'h0000_0000;
            ex_xfer_pc <= 1'b0;
            mem_load   <= 1'b0;
            mem_late   <= 1'b0;
            mem_rd     <= 4'h0;
            o_base_reg <= 4'h0;
            o_base_val <= 32'h0000_0000;
        end else if (advance) begin
            ex_load    <= is_load;
            ex_late    <= is_load && ins[22];
            ex_rd      <= f_rd;
            ex_pc      <= i_dec.pc;
            ex_xfer_pc <= is_xfer && (f_rd == cic_pkg::PROGRAM_COUNTER_REG);
            mem_load   <= ex_load;
            mem_late   <= ex_late;
            mem_rd     <= ex_rd;
            o_base_reg <= f_rn;       // base as it stood before the access
            o_base_val <= i_base_val;
        end else if (!i_confirm) begin
            // a bubble moves down while execute repeats
            mem_load   <= ex_load;
            mem_late   <= ex_late;
            mem_rd     <= ex_rd;
            ex_load    <= 1'b0;
            ex_late    <= 1'b0;
        end
    end

    // stored pc value is the store's own address plus 8
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_store_data  <= 32'h0000_0000;
            o_store_valid <= 1'b0;
        end else begin
            o_store_valid <= i_st_beat;
            if (i_st_beat)
                o_store_data <= (i_st_reg == cic_pkg::PROGRAM_COUNTER_REG)
                              ? ex_pc + cic_pkg::PC_STORE_OFFSET
                              : i_st_val;
        end
    end

    // abort restore and undefined-result flag
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_base_restore      <= 1'b0;
            o_no_defined_result <= 1'b0;
        end else begin
            o_base_restore      <= i_data_abort;
            o_no_defined_result <= (advance && bad_encoding)
                                 || (ex_xfer_pc && (i_ea_lo != 2'b00));
        end
    end

    // ----------------------------------------------------------------
    // memory requests and responses
    // ----------------------------------------------------------------
    cic_pkg::cic_mreq_s req_q;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= '0;
            o_rsp <= '0;
        end else begin
            req_q <= i_req;
            if (!i_confirm)
                o_rsp <= i_rsp;
        end
    end

    // requests only fall as replies arrive, so they stay monotonic
    always_comb begin
        o_req = req_q;
        if (i_confirm) begin
            o_req.addr_ask                = req_q.addr_ask && !i_rsp.addr_reply;
            o_req.read_ask_data           = req_q.read_ask_data
                                          && !i_rsp.data_side_used_up;
            o_req.read_ask_instr_prefetch = req_q.read_ask_instr_prefetch
                                          && !i_rsp.instr_side_used_up;
        end
    end

    // ----------------------------------------------------------------
    // prefetch occupancy; data stores never flush it
    // ----------------------------------------------------------------
    logic [3:0] pf_cnt;

    assign o_pf_ready = (pf_cnt != cic_pkg::PREFETCH_DEPTH);

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            pf_cnt     <= 4'h0;
            o_pf_flush <= 1'b0;
        end else begin
            o_pf_flush <= advance && is_barrier;
            if (advance && is_barrier)
                pf_cnt <= 4'h0;
            else if ((i_pf_push && o_pf_ready) && !(i_pf_pop && pf_cnt != 4'h0))
                pf_cnt <= pf_cnt + 4'h1;
            else if (!(i_pf_push && o_pf_ready) && (i_pf_pop && pf_cnt != 4'h0))
                pf_cnt <= pf_cnt - 4'h1;
        end
    end

endmodule : cic_core_ctl

// ---- cic_mem_model.sv ----
`timescale 1ns/1ps

module cic_mem_model (
    // clock
    input  wire logic               i_mclk,
    // requests from the core and fault command
    input  wire cic_pkg::cic_mreq_s i_req,
    input  wire logic               i_wrong,
    // answers toward the core
    output cic_pkg::cic_mrsp_s      o_rsp,
    output logic                    o_confirm
);
    // ----------------------------------------------------------------
    // single-cycle memory, never used up
    // ----------------------------------------------------------------
    cic_pkg::cic_mrsp_s good;
    cic_pkg::cic_mrsp_s last_good;

    // every request is granted in the same cycle
    always_comb begin
        good.addr_reply         = i_req.addr_ask;
        good.read_reply         = i_req.read_ask_data | i_req.read_ask_instr_core
                                  | i_req.read_ask_instr_prefetch;
        good.data_side_used_up  = 1'b0;
        good.instr_side_used_up = 1'b0;
    end

    // wrong answers come from a held copy, so no loop through the masked requests
    always_ff @(posedge i_mclk) begin
        last_good <= good;
    end

    // a wrong provisional answer is flagged by confirm in the same cycle
    assign o_rsp     = i_wrong ? cic_pkg::cic_mrsp_s'(~last_good) : good;
    assign o_confirm = i_wrong;
endmodule : cic_mem_model

// ---- cic_core_monitor.sv ----
`timescale 1ns/1ps

module cic_core_monitor (
    // clock and reset
    input wire logic               i_mclk,
    input wire logic               i_rst_n,
    // decode and execute side
    input wire cic_pkg::cic_dec_s  i_dec,
    input wire logic               o_dec_ready,
    input wire logic [31:0]        i_base_val,
    input wire logic               i_st_beat,
    input wire logic [3:0]         i_st_reg,
    input wire logic               i_data_abort,
    // memory side
    input wire cic_pkg::cic_mreq_s i_req,
    input wire cic_pkg::cic_mrsp_s i_rsp,
    input wire logic               i_confirm,
    input wire cic_pkg::cic_mreq_s o_req,
    input wire cic_pkg::cic_mrsp_s o_rsp,
    // results
    input wire logic               o_pf_flush,
    input wire logic               o_interlock,
    input wire logic               o_undef_take,
    input wire logic [31:0]        o_undef_vector,
    input wire logic [31:0]        o_store_data,
    input wire logic               o_store_valid,
    input wire logic               o_base_restore,
    input wire logic [31:0]        o_base_val
);
    // ----------------------------------------------------------------
    // helper state
    // ----------------------------------------------------------------
    logic [2:0]  live;
    logic [31:0] take_pc;
    logic [31:0] take_base;
    logic        take;

    // checks wait until the internal reset copy has let go
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            live <= 3'h0;
        end else begin
            live <= {live[1:0], 1'b1};
        end
    end

    // pc and base of the last accepted instruction
    assign take = i_dec.valid && o_dec_ready;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            take_pc   <= 32'h0;
            take_base <= 32'h0;
        end else if (take) begin
            take_pc   <= i_dec.pc;
            take_base <= i_base_val;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!live[2]);

    sequence s_undef_start;
        $rose(i_dec.valid) && i_dec.instr[31:28] == cic_pkg::COND_NEVER;
    endsequence
    sequence s_trap_run;
        (!o_dec_ready && !o_undef_take) [*4];
    endsequence

    chk_undef_cost: assert property (s_undef_start |=> s_trap_run ##1 o_undef_take)
        else $error("trap cost wrong");
    chk_undef_vec: assert property (o_undef_take |-> o_undef_vector == cic_pkg::UNDEF_VECTOR)
        else $error("trap vector wrong");
    chk_stall_max: assert property (o_interlock [*2] |=> !o_interlock)
        else $error("stall too long");
    chk_stall_hold: assert property (o_interlock |-> !o_dec_ready)
        else $error("taken while stalled");
    chk_confirm_hold: assert property (i_confirm |-> !o_dec_ready)
        else $error("taken under confirm");
    chk_reply_keep: assert property (i_confirm |=> o_rsp == $past(o_rsp))
        else $error("reply not held");
    chk_reply_take: assert property (!i_confirm |=> o_rsp == $past(i_rsp))
        else $error("reply not taken");
    chk_req_follow: assert property (!i_confirm ##1 !i_confirm |-> o_req == $past(i_req))
        else $error("request not passed");
    chk_pc_store: assert property (i_st_beat && i_st_reg == cic_pkg::PROGRAM_COUNTER_REG && !take
        |=> o_store_valid && o_store_data == take_pc + cic_pkg::PC_STORE_OFFSET)
        else $error("pc store value wrong");
    chk_abort_base: assert property (i_data_abort && !take
        |=> o_base_restore && o_base_val == take_base)
        else $error("base not restored");
    chk_flush_take: assert property (take && i_dec.instr[27:0] == {4'hF, cic_pkg::BARRIER_IMM}
        |=> o_pf_flush)
        else $error("barrier did not flush");
endmodule : cic_core_monitor

bind cic_core_ctl cic_core_monitor u_cic_core_monitor (
    .i_mclk, .i_rst_n, .i_dec, .o_dec_ready, .i_base_val, .i_st_beat, .i_st_reg,
    .i_data_abort, .i_req, .i_rsp, .i_confirm, .o_req, .o_rsp, .o_pf_flush, .o_interlock,
    .o_undef_take, .o_undef_vector, .o_store_data, .o_store_valid, .o_base_restore, .o_base_val
);

// ---- tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
    // ----------------------------------------------------------------
    // stimulus, observation and bookkeeping
    // ----------------------------------------------------------------
    localparam logic [31:0] INDEP = 32'hE0853004;
    localparam logic [31:0] USER  = 32'hE0813004;
    // store whose only link to the load is its data register
    localparam logic [31:0] STDAT = 32'hE5851000;
    logic               i_mclk = 1'b0, i_rst_n = 1'b0, i_st_beat = 1'b0, i_data_abort = 1'b0;
    logic               i_pf_push = 1'b0, i_pf_pop = 1'b0, wrong = 1'b0, i_confirm;
    cic_pkg::cic_dec_s  i_dec = '0;
    cic_pkg::cic_mreq_s i_req = '0, o_req;
    cic_pkg::cic_mrsp_s i_rsp, o_rsp;
    logic [3:0]         i_st_reg = 4'h0, o_base_reg;
    logic [1:0]         i_ea_lo = 2'h0;
    logic [31:0]        i_base_val = 32'h0, i_st_val = 32'h0, pc = 32'h100;
    logic [31:0]        o_undef_vector, o_store_data, o_base_val;
    logic               o_dec_ready, o_pf_ready, o_pf_flush, o_interlock, o_undef_take;
    logic               o_store_valid, o_base_restore, o_no_defined_result;
    int                 err_count = 0, tests_run = 0, ilk_n, ndr_n, flush_n;

    cic_core_ctl u_cic_core_ctl (
        .i_mclk, .i_rst_n, .i_dec, .o_dec_ready, .i_base_val, .i_ea_lo,
        .i_st_beat, .i_st_reg, .i_st_val, .i_data_abort, .i_req, .i_rsp, .i_confirm,
        .o_req, .o_rsp, .i_pf_push, .i_pf_pop, .o_pf_ready, .o_pf_flush, .o_interlock,
        .o_undef_take, .o_undef_vector, .o_store_data, .o_store_valid, .o_base_restore,
        .o_base_reg, .o_base_val, .o_no_defined_result
    );
    cic_mem_model u_cic_mem_model (
        .i_mclk, .i_req(o_req), .i_wrong(wrong), .o_rsp(i_rsp), .o_confirm(i_confirm)
    );

    // 100 ns clock
    initial begin
        forever #50 i_mclk = ~i_mclk;
    end

    // pulse counts taken mid-cycle, where registered outputs have settled
    always @(negedge i_mclk) begin
        ilk_n += (o_interlock === 1'b1);
        ndr_n += (o_no_defined_result === 1'b1);
        flush_n += (o_pf_flush === 1'b1);
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // offer held until taken; returns on the taking edge
    task automatic offer(input logic [31:0] ins);
        int n;
        n = 0;
        i_dec <= '{1'b1, ins, pc};
        #1;
        while (o_dec_ready !== 1'b1 && n < 20) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        if (n == 20) begin
            err_count++;
            give_verdict();
        end
        @(posedge i_mclk);
        pc = pc + 32'h4;
    endtask : offer

    task automatic idle(input int n);
        i_dec <= '0;
        repeat (n) @(posedge i_mclk);
    endtask : idle

    task automatic t_undef;
        logic [31:0] u [2];
        int n;
        u = '{32'hF0000000, 32'hE6000010};
        foreach (u[k]) begin
            n = 0;
            i_dec <= '{1'b1, u[k], pc};
            do begin
                @(posedge i_mclk);
                #1;
                n++;
            end while (o_undef_take !== 1'b1 && n < 20);
            check("trap cost", n, cic_pkg::UNDEF_CYCLES + 1);
            check("trap vector", o_undef_vector, cic_pkg::UNDEF_VECTOR);
            @(posedge i_mclk);
            idle(8);
        end
    endtask : t_undef

    // word, byte, independent, byte with one between, store data after word and byte
    task automatic t_interlock;
        logic [31:0] ld [6];
        logic [31:0] us [6];
        int ex [6];
        ld = '{32'hE5921000, 32'hE5D21000, 32'hE5921000, 32'hE5D21000, 32'hE5921000,
               32'hE5D21000};
        us = '{USER, USER, INDEP, USER, STDAT, STDAT};
        ex = '{1, 2, 0, 1, 0, 1};
        for (int i = 0; i < 6; i++) begin
            ilk_n = 0;
            offer(ld[i]);
            if (i == 3) offer(INDEP);
            offer(us[i]);
            idle(3);
            check("stall cycles", ilk_n, ex[i]);
        end
    endtask : t_interlock

    task automatic st(input logic [3:0] r, input logic [31:0] v, input logic [31:0] e);
        i_st_beat <= 1'b1;
        i_st_reg <= r;
        i_st_val <= v;
        @(posedge i_mclk);
        i_st_beat <= 1'b0;
        #1;
        check("store valid", o_store_valid, 1'b1);
        check("store data", o_store_data, e);
        @(posedge i_mclk);
    endtask : st

    // single pc store, then a multiple store walking r3 and pc
    task automatic t_store;
        logic [31:0] p;
        offer(INDEP);
        p = pc - 32'h4;
        idle(1);
        st(4'hF, 32'h0, p + 32'h8);
        st(4'h3, 32'h1234_5678, 32'h1234_5678);
        st(4'hF, 32'h0, p + 32'h8);
    endtask : t_store

    task automatic t_abort;
        i_base_val <= 32'h2000;
        offer(32'hE5B21004);
        i_dec <= '0;
        i_base_val <= 32'h3000;
        i_data_abort <= 1'b1;
        @(posedge i_mclk);
        i_data_abort <= 1'b0;
        #1;
        check("restore", o_base_restore, 1'b1);
        check("base reg", o_base_reg, 4'h2);
        check("base value", o_base_val, 32'h2000);
        @(posedge i_mclk);
    endtask : t_abort

    // three invalid forms, a misaligned pc load and one lawful register shift
    task automatic t_bad_forms;
        logic [31:0] b [5];
        b = '{32'hE08F0211, 32'hEE00FF10, 32'hE5B11004, 32'hE592F000, 32'hE0810312};
        ndr_n = 0;
        foreach (b[k]) begin
            offer(b[k]);
            i_dec <= '0;
            i_ea_lo <= (k == 3) ? 2'h2 : 2'h0;
            @(posedge i_mclk);
            i_ea_lo <= 2'h0;
            idle(1);
        end
        check("undefined results", ndr_n, 4);
    endtask : t_bad_forms

    task automatic t_prefetch;
        i_pf_push <= 1'b1;
        repeat (13) @(posedge i_mclk);
        i_pf_push <= 1'b0;
        #1;
        check("prefetch full", o_pf_ready, 1'b0);
        @(posedge i_mclk);
        i_pf_pop <= 1'b1;
        @(posedge i_mclk);
        i_pf_pop <= 1'b0;
        flush_n = 0;
        offer(32'hEFF00000);
        idle(2);
        check("flush pulses", flush_n, 1);
        i_pf_push <= 1'b1;
        repeat (11) @(posedge i_mclk);
        i_pf_push <= 1'b0;
        #1;
        check("prefetch emptied", o_pf_ready, 1'b1);
        @(posedge i_mclk);
    endtask : t_prefetch

    // wrong provisional replies must not be taken nor let decode advance
    task automatic t_confirm;
        i_req <= '{32'h100, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        repeat (3) @(posedge i_mclk);
        wrong <= 1'b1;
        i_dec <= '{1'b1, INDEP, pc};
        #1;
        check("ready in confirm", o_dec_ready, 1'b0);
        check("masked data ask", o_req.read_ask_data, 1'b0);
        @(posedge i_mclk);
        wrong <= 1'b0;
        #1;
        check("held reply", o_rsp, 4'hC);
        check("ready after confirm", o_dec_ready, 1'b1);
        @(posedge i_mclk);
        i_dec <= '0;
        pc = pc + 32'h4;
        @(posedge i_mclk);
    endtask : t_confirm

    initial begin
        repeat (10) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
        t_undef();
        t_interlock();
        t_store();
        t_abort();
        t_bad_forms();
        t_prefetch();
        t_confirm();
        give_verdict();
    end
endmodule : tb_top
